// file: sbp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbp_map.svh"
module sbp_ctrl import sbp_pkg::*; #(
  parameter int ROW_W = 12,
  parameter int COL_W = 9,
  parameter int DATA_W = 16,
  parameter int READ_LAT = 3,
  parameter int PD_MAX_CYCLES = `SBP_PD_MAX_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // access request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [1:0] reqBank,
  input wire logic [ROW_W-1:0] reqRow,
  input wire logic [COL_W-1:0] reqCol,
  input wire logic [DATA_W-1:0] reqData,
  // read answer
  output logic rdValid,
  output logic [DATA_W-1:0] rdData,
  // power-down request
  input wire logic pdReq,
  output logic pdActive,
  // link to the memory
  sbp_link_if.ctrl link
);
  localparam int CNT_W = $clog2(PD_MAX_CYCLES + 1);
  // minimum times in whole clocks, rounded up; write recovery one clock more
  localparam int RCD_CYC = `SBP_RCD_CYC;
  localparam int RP_CYC = `SBP_RP_CYC;
  localparam int WR_CYC = `SBP_WR_CYC;

  sbp_ctrl_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic wr_q;
  logic [1:0] bank_q;
  logic [ROW_W-1:0] row_q;
  logic [COL_W-1:0] col_q;
  logic [DATA_W-1:0] data_q, rdData_q;
  logic rdValid_q;

  // ==========================================================
  // request acceptance
  wire logic take = (state_q == ST_IDLE) && !pdReq && reqValid;
  wire logic cntDone = (cnt_q == '0);
  // the single read word is on the bus at the last wait cycle
  wire logic rdCapture = (state_q == ST_RD_WAIT) && cntDone;

  // ==========================================================
  // sequencer: every access is one word, closed again by an
  // explicit precharge, so each access starts with an activate
  always_comb begin
    state_d = state_q;
    cnt_d = cntDone ? cnt_q : cnt_q - 1'b1;
    unique case (state_q)
      ST_IDLE: begin
        if (pdReq) begin
          state_d = ST_POWER_DOWN;
          cnt_d = CNT_W'(PD_MAX_CYCLES - 1);
        end else if (reqValid) begin
          state_d = ST_ACTIVATE;
        end
      end
      ST_ACTIVATE: begin
        state_d = ST_ACT_WAIT;
        cnt_d = CNT_W'(RCD_CYC - 1);
      end
      ST_ACT_WAIT: begin
        if (cntDone) begin
          state_d = wr_q ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: begin
        state_d = ST_WR_TERM;
      end
      ST_WR_TERM: begin
        state_d = ST_WR_RECOVER;
        cnt_d = CNT_W'(WR_CYC - 1);
      end
      ST_WR_RECOVER: begin
        if (cntDone) begin
          state_d = ST_PRECHARGE;
        end
      end
      ST_READ: begin
        state_d = ST_RD_TERM;
      end
      ST_RD_TERM: begin
        state_d = ST_RD_WAIT;
        cnt_d = CNT_W'(READ_LAT - 2);
      end
      ST_RD_WAIT: begin
        if (cntDone) begin
          state_d = ST_PRECHARGE;
        end
      end
      ST_PRECHARGE: begin
        state_d = ST_PRE_WAIT;
        cnt_d = CNT_W'(RP_CYC - 1);
      end
      ST_PRE_WAIT: begin
        if (cntDone) begin
          state_d = ST_IDLE;
        end
      end
      ST_POWER_DOWN: begin
        // leave on request, or before refresh is overdue
        if (!pdReq || cntDone) begin
          state_d = ST_PD_EXIT;
        end
      end
      ST_PD_EXIT: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // request fields held for the whole access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      bank_q <= 2'h0;
      row_q <= '0;
      col_q <= '0;
      data_q <= '0;
    end else if (take) begin
      wr_q <= reqWrite;
      bank_q <= reqBank;
      row_q <= reqRow;
      col_q <= reqCol;
      data_q <= reqData;
    end
  end

  // read answer, one pulse per read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid_q <= 1'b0;
      rdData_q <= '0;
    end else begin
      rdValid_q <= rdCapture;
      if (rdCapture) begin
        rdData_q <= link.dataIo;
      end
    end
  end

  // ==========================================================
  // command encoding; the terminate right after the read keeps
  // the burst to one word whatever burst length the memory uses
  wire logic [2:0] cmdCode =
    (state_q == ST_ACTIVATE) ? `SBP_CODE_ACTIVE :
    (state_q == ST_WRITE) ? `SBP_CODE_WRITE :
    (state_q == ST_READ) ? `SBP_CODE_READ :
    (state_q == ST_WR_TERM) ? `SBP_CODE_TERMINATE :
    (state_q == ST_RD_TERM) ? `SBP_CODE_TERMINATE :
    (state_q == ST_PRECHARGE) ? `SBP_CODE_PRECHARGE :
    `SBP_CODE_NOP;
  // column addresses leave the all-bank and auto-precharge bit low
  wire logic [ROW_W-1:0] addrOut =
    (state_q == ST_ACTIVATE) ? row_q :
    ((state_q == ST_WRITE) || (state_q == ST_READ)) ? ROW_W'(col_q) :
    '0;
  // mask is low only around a read and on the write edge itself;
  // the idle, activate and wait cycles keep it high well before a
  // write, and the write terminate and precharge edges keep it high
  wire logic maskLow = (state_q == ST_WRITE) ||
    (state_q == ST_READ) || (state_q == ST_RD_TERM) ||
    (state_q == ST_RD_WAIT);

  // ==========================================================
  // link outputs
  assign link.clockGateInput = (state_q != ST_POWER_DOWN);
  assign link.chipSelN = 1'b0;
  assign {link.rowStrobeN, link.colStrobeN, link.writeEnN} = cmdCode;
  assign link.bankSelectLow = bank_q[0];
  assign link.bankSelectHigh = bank_q[1];
  assign link.addr = addrOut;
  assign link.dataMaskLine = !maskLow;
  // data goes out only with the write it belongs to
  assign link.ctrlDataOut = data_q;
  assign link.ctrlDataOe = (state_q == ST_WRITE);

  // ==========================================================
  // user side
  assign reqReady = (state_q == ST_IDLE) && !pdReq;
  assign rdValid = rdValid_q;
  assign rdData = rdData_q;
  assign pdActive = (state_q == ST_POWER_DOWN);
endmodule : sbp_ctrl
`default_nettype wire

// file: sbp_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// link watch: both ends are design code
module sbp_link_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // command lines
  input wire logic clockGateInput,
  input wire logic chipSelN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnN,
  input wire logic dataMaskLine,
  // data enables
  input wire logic ctrlDataOe,
  input wire logic memDataOe
);
  // command decode; a deselected chip counts as a no-operation
  wire [2:0] code = {rowStrobeN, colStrobeN, writeEnN};
  wire isWr = !chipSelN && code == 3'h4;
  wire isRd = !chipSelN && code == 3'h5;
  wire isTerm = !chipSelN && code == 3'h6;
  wire isPre = !chipSelN && code == 3'h2;
  wire isNop = chipSelN || code == 3'h7;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wr_mask_a: assert property (isWr |-> !dataMaskLine && ctrlDataOe)
    else $error("mask high or data off at write");
  wr_mask_lead_a: assert property (
    isWr |-> $past(dataMaskLine, 2) && $past(dataMaskLine))
    else $error("mask not high two clocks before write");
  wr_recover_a: assert property (isWr |=> isTerm ##3 isPre)
    else $error("precharge after write not at recovery bound");
  wr_pre_mask_a: assert property (
    isWr |-> ##4 dataMaskLine && $past(dataMaskLine))
    else $error("mask low around write-ending precharge");
  pre_recover_a: assert property (isPre |=> isNop)
    else $error("command right after precharge");
  rd_term_a: assert property (isRd |=> isTerm)
    else $error("terminate not one clock after read");
  rd_data_a: assert property (
    isRd |-> ##3 memDataOe ##1 !memDataOe)
    else $error("read word not single at latency");
  rd_pre_a: assert property (isRd |-> ##4 isPre)
    else $error("precharge after read misplaced");
  bus_fight_a: assert property (!(memDataOe && ctrlDataOe))
    else $error("both ends drive data");
  pd_nop_a: assert property (!clockGateInput |-> isNop)
    else $error("command with clock gate low");
  pd_exit_a: assert property ($rose(clockGateInput) |-> isNop)
    else $error("power-down left without no-operation");
endmodule : sbp_link_assertions
`default_nettype wire

// file: sbp_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sbp_link_if #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 16
) ();
  // ==========================================================
  // command, address and mask, driven by the controller
  logic clockGateInput;
  logic chipSelN;
  logic rowStrobeN;
  logic colStrobeN;
  logic writeEnN;
  logic bankSelectLow;
  logic bankSelectHigh;
  logic [ADDR_W-1:0] addr;
  logic dataMaskLine;
  // two-way data: each end gives value and enable
  logic [DATA_W-1:0] ctrlDataOut;
  logic ctrlDataOe;
  logic [DATA_W-1:0] memDataOut;
  logic memDataOe;
  wire [DATA_W-1:0] dataIo;
  // resolved bus; both enables high is a bus fight, and an
  // undriven bus reads as zero since nothing on chip floats
  assign dataIo = memDataOe ? memDataOut :
                  ctrlDataOe ? ctrlDataOut : {DATA_W{1'b0}};
  modport mem (
    input clockGateInput, chipSelN, rowStrobeN, colStrobeN, writeEnN,
    input bankSelectLow, bankSelectHigh, addr, dataMaskLine, dataIo,
    output memDataOut, memDataOe
  );
  modport ctrl (
    output clockGateInput, chipSelN, rowStrobeN, colStrobeN, writeEnN,
    output bankSelectLow, bankSelectHigh, addr, dataMaskLine,
    output ctrlDataOut, ctrlDataOe,
    input dataIo
  );
endinterface : sbp_link_if
`default_nettype wire

// file: sbp_map.svh
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH
// ==========================================================
// command codes on {row strobe, column strobe, write enable}
`define SBP_CODE_ACTIVE 3'h3
`define SBP_CODE_READ 3'h5
`define SBP_CODE_WRITE 3'h4
`define SBP_CODE_TERMINATE 3'h6
`define SBP_CODE_PRECHARGE 3'h2
`define SBP_CODE_REFRESH 3'h1
`define SBP_CODE_MODE 3'h0
`define SBP_CODE_NOP 3'h7
// ==========================================================
// address field positions
`define SBP_ALL_BANK_BIT 10
// ==========================================================
// reset values of the controller's link outputs
`define SBP_CKE_RESET 1'h1
`define SBP_MASK_RESET 1'h1
// ==========================================================
// timing: times as printed, counts derived from the clock
`define SBP_CLK_PERIOD_NS 40
`define SBP_T_RP_NS 20
`define SBP_T_RCD_NS 20
`define SBP_T_WR_NS 15
`define SBP_T_PD_MAX_MS 64
`define SBP_CYC_UP(t) (((t) + `SBP_CLK_PERIOD_NS - 1) / `SBP_CLK_PERIOD_NS)
`define SBP_RP_CYC `SBP_CYC_UP(`SBP_T_RP_NS)
`define SBP_RCD_CYC `SBP_CYC_UP(`SBP_T_RCD_NS)
`define SBP_WR_CYC (1 + `SBP_CYC_UP(`SBP_T_WR_NS))
`define SBP_PD_MAX_CYC (`SBP_T_PD_MAX_MS * 1000000 / `SBP_CLK_PERIOD_NS)
`endif

// file: sbp_memory.sv
`timescale 1ns/100ps
`default_nettype none
`include "sbp_map.svh"
module sbp_memory import sbp_pkg::*; #(
  parameter int COL_W = 9,
  parameter int DATA_W = 16,
  parameter int READ_LAT = 3,
  parameter int BURST_LEN = 4,
  parameter bit FULL_PAGE = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link to the controller
  sbp_link_if.mem link,
  // status
  output logic powerDown,
  output logic activePowerDown,
  output logic [3:0] bankOpen
);
  localparam logic [COL_W-1:0] BL_MASK = COL_W'(BURST_LEN - 1);

  // ==========================================================
  // command decode
  // next column: full page wraps at the page end, else in the burst
  function automatic logic [COL_W-1:0] nextCol(input logic [COL_W-1:0] c);
    logic [COL_W-1:0] inc;
    inc = c + 1'b1;
    if (FULL_PAGE) begin
      return inc;
    end
    return (c & ~BL_MASK) | (inc & BL_MASK);
  endfunction : nextCol

  logic pd_q, ckePrev_q, activePd_q;
  logic [3:0] open_q;
  logic wrActive_q, wrAp_q, rdActive_q, rdAp_q;
  logic [1:0] wrBank_q, rdBank_q, dqmDly_q;
  logic [COL_W-1:0] wrCol_q, rdCol_q;
  logic [COL_W:0] wrLeft_q, rdLeft_q;
  logic [READ_LAT-1:0] pipeVal_q;
  logic [DATA_W-1:0] pipeData_q [READ_LAT];
  logic [DATA_W-1:0] mem_q [4 * 2 ** COL_W];

  wire sbp_cmd_type cmd = sbp_decode(link.chipSelN,
    {link.rowStrobeN, link.colStrobeN, link.writeEnN});
  // a low clock gate suspends the next edge; power-down blanks all
  wire logic live = ckePrev_q && !pd_q;
  wire logic idleCmd = (cmd == CMD_NOP) || (cmd == CMD_INHIBIT);
  wire logic [1:0] cmdBank = {link.bankSelectHigh, link.bankSelectLow};
  wire logic [COL_W-1:0] cmdCol = link.addr[COL_W-1:0];
  wire logic allBankFlag = link.addr[`SBP_ALL_BANK_BIT];
  wire logic cmdRd = live && (cmd == CMD_READ);
  wire logic cmdWr = live && (cmd == CMD_WRITE);
  wire logic cmdTerm = live && (cmd == CMD_TERMINATE);
  wire logic cmdPre = live && (cmd == CMD_PRECHARGE);
  wire logic cmdAct = live && (cmd == CMD_ACTIVE);
  wire logic rdBusy = rdActive_q || (|pipeVal_q);
  wire logic lastWord = !FULL_PAGE && (wrLeft_q == (COL_W + 1)'(1));
  wire logic lastRead = !FULL_PAGE && (rdLeft_q == (COL_W + 1)'(1));

  // ==========================================================
  // write burst: any access command, or a precharge hitting the
  // burst's bank, ends it; the word on that edge is not stored
  wire logic wrStop = cmdRd || cmdWr || cmdTerm ||
    (cmdPre && (allBankFlag || cmdBank == wrBank_q));
  wire logic burstWr = live && wrActive_q && !wrStop;
  // mask has no latency on input data
  wire logic memWe = (cmdWr || burstWr) && !link.dataMaskLine;
  wire logic [COL_W+1:0] wrIdx = cmdWr ? {cmdBank, cmdCol}
                                       : {wrBank_q, wrCol_q};
  wire logic wrApDone = (burstWr && lastWord && wrAp_q) ||
    (cmdWr && allBankFlag && !FULL_PAGE && BURST_LEN == 1);

  // ==========================================================
  // read burst
  wire logic rdStop = cmdRd || cmdWr || cmdTerm ||
    (cmdPre && (allBankFlag || cmdBank == rdBank_q));
  wire logic rdMore = live && rdActive_q && !rdStop;
  wire logic rdFetch = cmdRd || rdMore;
  wire logic [COL_W+1:0] rdIdx = cmdRd ? {cmdBank, cmdCol}
                                       : {rdBank_q, rdCol_q};
  wire logic rdApDone = (rdMore && lastRead && rdAp_q) ||
    (cmdRd && allBankFlag && !FULL_PAGE && BURST_LEN == 1);

  // ==========================================================
  // bank state
  wire logic [3:0] preMask = allBankFlag ? 4'hf
                                         : sbp_bank_onehot(cmdBank);
  wire logic [3:0] closeMask = (cmdPre ? preMask : 4'h0) |
    (wrApDone ? sbp_bank_onehot(wrBank_q) : 4'h0) |
    (rdApDone ? sbp_bank_onehot(rdBank_q) : 4'h0);
  wire logic [3:0] open_d = (open_q & ~closeMask) |
    (cmdAct ? sbp_bank_onehot(cmdBank) : 4'h0);

  // ==========================================================
  // power-down: entered only with nothing in flight
  wire logic enterPd = live && !link.clockGateInput && idleCmd &&
    !wrActive_q && !rdBusy;
  wire logic exitPd = pd_q && link.clockGateInput && idleCmd;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_q <= 1'b0;
      activePd_q <= 1'b0;
      ckePrev_q <= 1'b0;
      open_q <= 4'h0;
    end else begin
      pd_q <= (pd_q && !exitPd) || enterPd;
      activePd_q <= enterPd ? (|open_q) : (activePd_q && !exitPd);
      ckePrev_q <= link.clockGateInput;
      open_q <= open_d;
    end
  end

  // write burst tracking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrActive_q <= 1'b0;
      wrAp_q <= 1'b0;
      wrBank_q <= 2'h0;
      wrCol_q <= '0;
      wrLeft_q <= '0;
    end else if (cmdWr) begin
      wrActive_q <= FULL_PAGE || (BURST_LEN > 1);
      wrAp_q <= allBankFlag;
      wrBank_q <= cmdBank;
      wrCol_q <= nextCol(cmdCol);
      wrLeft_q <= (COL_W + 1)'(BURST_LEN - 1);
    end else if (burstWr) begin
      wrActive_q <= !lastWord;
      wrCol_q <= nextCol(wrCol_q);
      wrLeft_q <= wrLeft_q - 1'b1;
    end else if (live && wrStop) begin
      wrActive_q <= 1'b0;
    end
  end

  // read burst tracking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdActive_q <= 1'b0;
      rdAp_q <= 1'b0;
      rdBank_q <= 2'h0;
      rdCol_q <= '0;
      rdLeft_q <= '0;
    end else if (cmdRd) begin
      rdActive_q <= FULL_PAGE || (BURST_LEN > 1);
      rdAp_q <= allBankFlag;
      rdBank_q <= cmdBank;
      rdCol_q <= nextCol(cmdCol);
      rdLeft_q <= (COL_W + 1)'(BURST_LEN - 1);
    end else if (rdMore) begin
      rdActive_q <= !lastRead;
      rdCol_q <= nextCol(rdCol_q);
      rdLeft_q <= rdLeft_q - 1'b1;
    end else if (live && rdStop) begin
      rdActive_q <= 1'b0;
    end
  end

  // ==========================================================
  // storage: no reset, contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      mem_q[wrIdx] <= link.dataIo;
    end
  end

  // read pipeline head; a write clears every stage so the memory stops driving the bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pipeVal_q[0] <= 1'b0;
      pipeData_q[0] <= '0;
      dqmDly_q <= 2'h0;
    end else if (live) begin
      pipeVal_q[0] <= rdFetch;
      pipeData_q[0] <= mem_q[rdIdx];
      dqmDly_q <= {dqmDly_q[0], link.dataMaskLine};
    end
  end

  // remaining stages hold still while the clock is suspended
  for (genvar i = 1; i < READ_LAT; i++) begin : g_pipe
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pipeVal_q[i] <= 1'b0;
        pipeData_q[i] <= '0;
      end else if (cmdWr) begin
        pipeVal_q[i] <= 1'b0;
        pipeData_q[i] <= pipeData_q[i-1];
      end else if (live) begin
        pipeVal_q[i] <= pipeVal_q[i-1];
        pipeData_q[i] <= pipeData_q[i-1];
      end
    end
  end

  // ==========================================================
  // outputs: mask acts two edges late on the output buffer
  assign link.memDataOut = pipeData_q[READ_LAT-1];
  assign link.memDataOe = pipeVal_q[READ_LAT-1] && !dqmDly_q[1] &&
    !pd_q;
  assign powerDown = pd_q;
  assign activePowerDown = activePd_q;
  assign bankOpen = open_q;
endmodule : sbp_memory
`default_nettype wire

// file: sbp_pkg.sv
`default_nettype none
`include "sbp_map.svh"
package sbp_pkg;
  // ==========================================================
  // decoded link command
  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACTIVE = 4'h2,
    CMD_READ = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_TERMINATE = 4'h5,
    CMD_PRECHARGE = 4'h6,
    CMD_REFRESH = 4'h7,
    CMD_MODE = 4'h8
  } sbp_cmd_type;
  // controller sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ACTIVATE = 4'h1,
    ST_ACT_WAIT = 4'h2,
    ST_WRITE = 4'h3,
    ST_WR_TERM = 4'h4,
    ST_WR_RECOVER = 4'h5,
    ST_READ = 4'h6,
    ST_RD_TERM = 4'h7,
    ST_RD_WAIT = 4'h8,
    ST_PRECHARGE = 4'h9,
    ST_PRE_WAIT = 4'ha,
    ST_POWER_DOWN = 4'hb,
    ST_PD_EXIT = 4'hc
  } sbp_ctrl_state_type;
  // ==========================================================
  // strobe pins to command; a deselected chip sees an inhibit
  function automatic sbp_cmd_type sbp_decode(input logic selN,
                                             input logic [2:0] code);
    sbp_cmd_type c;
    c = CMD_INHIBIT;
    if (!selN) begin
      unique case (code)
        `SBP_CODE_ACTIVE: c = CMD_ACTIVE;
        `SBP_CODE_READ: c = CMD_READ;
        `SBP_CODE_WRITE: c = CMD_WRITE;
        `SBP_CODE_TERMINATE: c = CMD_TERMINATE;
        `SBP_CODE_PRECHARGE: c = CMD_PRECHARGE;
        `SBP_CODE_REFRESH: c = CMD_REFRESH;
        `SBP_CODE_MODE: c = CMD_MODE;
        `SBP_CODE_NOP: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction : sbp_decode
  // bank number to one-hot mask
  function automatic logic [3:0] sbp_bank_onehot(input logic [1:0] b);
    return 4'h1 << b;
  endfunction : sbp_bank_onehot
endpackage : sbp_pkg
`default_nettype wire

// file: test_sdram_burst_precharge_powerdown.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// bench: controller and memory joined over the link
module test_sdram_burst_precharge_powerdown;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0, reqWrite = 1'b0, pdReq = 1'b0;
  logic [1:0] reqBank = 2'h0;
  logic [11:0] reqRow = 12'h000;
  logic [8:0] reqCol = 9'h000;
  logic [15:0] reqData = 16'h0000, rdData;
  logic reqReady, rdValid, pdActive, powerDown, activePowerDown;
  logic [3:0] bankOpen;
  int err_count = 0, tests_run = 0, cycles = 0, n;
  int mdl[int];
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  sbp_link_if #(.ADDR_W(12), .DATA_W(16)) link ();
  // short power-down limit keeps the run brief
  sbp_ctrl #(.PD_MAX_CYCLES(20)) i_sbp_ctrl (.ref_clk(ref_clk),
    .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqBank(reqBank), .reqRow(reqRow),
    .reqCol(reqCol), .reqData(reqData), .rdValid(rdValid),
    .rdData(rdData), .pdReq(pdReq), .pdActive(pdActive), .link(link));
  sbp_memory i_sbp_memory (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .powerDown(powerDown),
    .activePowerDown(activePowerDown), .bankOpen(bankOpen));
  sbp_link_assertions i_sbp_link_assertions (.ref_clk(ref_clk),
    .rst_n(rst_n), .clockGateInput(link.clockGateInput),
    .chipSelN(link.chipSelN), .rowStrobeN(link.rowStrobeN),
    .colStrobeN(link.colStrobeN), .writeEnN(link.writeEnN),
    .dataMaskLine(link.dataMaskLine), .ctrlDataOe(link.ctrlDataOe),
    .memDataOe(link.memDataOe));
  // hang guard: far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  task test_done;
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  // one access; a read is checked against the model
  task access(input logic wr, input logic [1:0] b, input logic [8:0] c,
              input logic [15:0] d);
    int k;
    k = 0;
    @(negedge ref_clk);
    reqValid = 1'b1;
    reqWrite = wr;
    reqBank = b;
    reqRow = 12'($urandom);
    reqCol = c;
    reqData = d;
    while (reqReady !== 1'b1 && k < 60) begin
      @(negedge ref_clk);
      k++;
    end
    // a request never taken counts against the run
    if (k == 60) err_count++;
    @(negedge ref_clk);
    reqValid = 1'b0;
    if (wr) mdl[{b, c}] = d;
    else begin
      k = 0;
      while (rdValid !== 1'b1 && k < 30) begin
        @(negedge ref_clk);
        k++;
      end
      cmp("rdValid", 16'h0001, {15'h0000, rdValid});
      cmp("rdData", 16'(mdl[{b, c}]), rdData);
    end
  endtask : access
  initial begin
    void'($urandom(32'h0000_cfd8));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    // every bank at both column ends, then read back
    for (int i = 0; i < 8; i++)
      access(1'b1, i[1:0], i[2] ? 9'h1ff : 9'h000, 16'($urandom));
    for (int i = 0; i < 8; i++)
      access(1'b0, i[1:0], i[2] ? 9'h1ff : 9'h000, 16'h0000);
    // overwrite must replace the earlier word
    access(1'b1, 2'h1, 9'h1ff, 16'($urandom));
    access(1'b0, 2'h1, 9'h1ff, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      reqBank = 2'($urandom);
      reqCol = 9'($urandom);
      access(1'b1, reqBank, reqCol, 16'($urandom));
      access(1'b0, reqBank, reqCol, 16'h0000);
    end
    // explicit precharge leaves every bank closed; the last read's
    // precharge lands one edge after its word is handed back
    repeat (2) @(negedge ref_clk);
    cmp("bankOpen", 16'h0000, {12'h000, bankOpen});
    // precharge power-down, held past the refresh limit
    pdReq = 1'b1;
    repeat (6) @(negedge ref_clk);
    cmp("pdActive", 16'h0001, {15'h0000, pdActive});
    cmp("powerDown", 16'h0001, {15'h0000, powerDown});
    cmp("activePD", 16'h0000, {15'h0000, activePowerDown});
    n = 0;
    while (pdActive === 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    cmp("pdLimit", 16'h0000, {15'h0000, pdActive});
    pdReq = 1'b0;
    repeat (4) @(negedge ref_clk);
    cmp("powerDown", 16'h0000, {15'h0000, powerDown});
    access(1'b0, 2'h2, 9'h000, 16'h0000);
    // reset in mid-run; stored words survive, rows closed
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    cmp("bankOpen", 16'h0000, {12'h000, bankOpen});
    access(1'b0, 2'h3, 9'h1ff, 16'h0000);
    test_done();
  end
endmodule : test_sdram_burst_precharge_powerdown
`default_nettype wire
